// >>> rtl/fpcs_pkg.sv
// constants, op codes and carrier types of the flash program host controller
package fpcs_pkg;

  // widths of the flash bus and depth of the write buffer
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BUF_MAX = 16;

  // clock
  localparam int CLK_NS = 10;

  // pin timing, in ns, and derived clock counts
  localparam int WE_PULSE_NS = 35;
  localparam int DATA_HOLD_NS = 20;
  localparam int READ_ACCESS_NS = 100;
  localparam int RST_LOW_NS = 500;
  localparam int RST_RECOVER_NS = 50;
  localparam int SYNC_STAGES = 2;
  localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_HOLD_CYC = (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_RECOVER_CYC = (RST_RECOVER_NS + CLK_NS - 1) / CLK_NS;

  // documented command codes
  localparam logic [DATA_W-1:0] CMD_BYPASS_ENTER = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_BYPASS_PROG = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT2 = 16'h0000;

  // status bit positions read back from the flash
  localparam int DATA_POLLING_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;
  localparam int TIMEOUT_ERROR_BIT = 5;
  localparam int BUFFER_ABORT_BIT = 1;

  // register map of the controller
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0c;
  localparam logic [7:0] REG_BUFIDX = 8'h10;
  localparam logic [7:0] REG_BUFDATA = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_RDATA = 8'h1c;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_BYPASS = 1;
  localparam int ST_SECURED = 2;
  localparam int ST_ACCEL = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_ABORT = 5;
  localparam int ST_REFUSED = 6;
  localparam int ST_DONE = 7;

  // operations written to the control register
  localparam logic [3:0] OP_WORD = 4'h1;
  localparam logic [3:0] OP_BYP_ENTER = 4'h2;
  localparam logic [3:0] OP_BYP_PROG = 4'h3;
  localparam logic [3:0] OP_BYP_EXIT = 4'h4;
  localparam logic [3:0] OP_BUF_PROG = 4'h5;
  localparam logic [3:0] OP_SEC_ENTER = 4'h6;
  localparam logic [3:0] OP_SEC_EXIT = 4'h7;
  localparam logic [3:0] OP_RESET = 4'h8;
  localparam logic [3:0] OP_ABORT_RESET = 4'h9;
  localparam logic [3:0] OP_ACC_ON = 4'ha;
  localparam logic [3:0] OP_ACC_OFF = 4'hb;
  localparam logic [3:0] OP_READ = 4'hc;
  localparam logic [3:0] OP_HW_RESET = 4'hd;

  // pins driven towards the flash
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dqOe_n;
    logic we_n;
    logic ce_n;
    logic oe_n;
  } fpcs_pins_t;

  // one bus cycle of a command sequence
  typedef struct packed {
    logic last;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpcs_cycle_t;

endpackage

// >>> rtl/fpcs_bus_cycle.sv
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fpcs_bus_cycle import fpcs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // request
  input wire logic start,
  input wire fpcs_cycle_t cyc,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  // flash pins
  input wire logic [DATA_W-1:0] dqIn,
  output fpcs_pins_t pins
);

  typedef enum logic [2:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD, P_READ} fpcs_phase_t;

  typedef struct packed {
    fpcs_phase_t ph;
    logic [7:0] cnt;
    logic isWr;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
    fpcs_pins_t pins;
  } fpcs_bus_state_t;

  localparam fpcs_pins_t PINS_IDLE = '{addr: '0, dq: '0, dqOe_n: 1'b1, we_n: 1'b1,
                                       ce_n: 1'b1, oe_n: 1'b1};

  fpcs_bus_state_t s;
  fpcs_bus_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.sync1 = dqIn;
    next_s.sync2 = s.sync1;
    unique case (s.ph)
      P_IDLE: begin
        if (start) begin
          // address settles one cycle before the strobe falls
          next_s.pins.addr = cyc.addr;
          next_s.pins.ce_n = 1'b0;
          next_s.pins.dq = cyc.data;
          next_s.pins.dqOe_n = ~cyc.wr;
          next_s.isWr = cyc.wr;
          next_s.ph = P_SETUP;
        end
      end
      P_SETUP: begin
        if (s.isWr) begin
          next_s.pins.we_n = 1'b0;
          next_s.cnt = 8'(WE_PULSE_CYC - 1);
          next_s.ph = P_STROBE;
        end else begin
          next_s.pins.oe_n = 1'b0;
          next_s.cnt = 8'(READ_ACCESS_CYC + SYNC_STAGES);
          next_s.ph = P_READ;
        end
      end
      P_STROBE: begin
        if (s.cnt == 8'h00) begin
          // data held past the rising strobe edge
          next_s.pins.we_n = 1'b1;
          next_s.cnt = 8'(DATA_HOLD_CYC - 1);
          next_s.ph = P_HOLD;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      P_HOLD: begin
        if (s.cnt == 8'h00) begin
          next_s.pins.ce_n = 1'b1;
          next_s.pins.dqOe_n = 1'b1;
          next_s.done = 1'b1;
          next_s.ph = P_IDLE;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      P_READ: begin
        if (s.cnt == 8'h00) begin
          next_s.rdata = s.sync2;
          next_s.pins.oe_n = 1'b1;
          next_s.pins.ce_n = 1'b1;
          next_s.done = 1'b1;
          next_s.ph = P_IDLE;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      default: next_s.ph = P_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{ph: P_IDLE, cnt: 8'h00, isWr: 1'b0, done: 1'b0, rdata: '0, sync1: '0,
             sync2: '0, pins: PINS_IDLE};
    end else if (en) begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign rdata = s.rdata;
  assign pins = s.pins;

endmodule
`default_nettype wire

// >>> rtl/fpcs_host.sv
// host controller issuing program command sequences to a nor flash
`timescale 1ns/1ps
`default_nettype none
module fpcs_host import fpcs_pkg::*; #(
  parameter int BUF_WORDS = BUF_MAX,
  parameter int POLL_LIMIT = 65535,
  parameter logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000111,
  parameter logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h000222,
  parameter logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h0011,
  parameter logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0022,
  parameter logic [DATA_W-1:0] PROG_SETUP = 16'h0033,
  parameter logic [DATA_W-1:0] BUF_LOAD = 16'h0044,
  parameter logic [DATA_W-1:0] BUF_CONFIRM = 16'h0055,
  parameter logic [DATA_W-1:0] SEC_ENTER = 16'h0066,
  parameter logic [DATA_W-1:0] SEC_EXIT1 = 16'h0077,
  parameter logic [DATA_W-1:0] SEC_EXIT2 = 16'h0000,
  parameter logic [DATA_W-1:0] RESET_CMD = 16'h0088
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // flash pins
  input wire logic [DATA_W-1:0] flashDqIn,
  output fpcs_pins_t flashPins,
  output logic flashReset_n,
  output logic accHighVoltage
);

  if (BUF_WORDS < 1 || BUF_WORDS > BUF_MAX) begin : gBufCheck
    $error("BUF_WORDS out of range");
  end
  if (POLL_LIMIT < 2 || POLL_LIMIT > 65535) begin : gPollCheck
    $error("POLL_LIMIT out of range");
  end

  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_RST_LOW, S_RST_WAIT} fpcs_host_state_t;

  typedef struct packed {
    fpcs_host_state_t st;
    logic [3:0] op;
    logic [4:0] step;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [7:0] count;
    logic [3:0] bufIdx;
    logic bypass;
    logic secured;
    logic accHigh;
    logic timeoutErr;
    logic bufAbort;
    logic refused;
    logic opDone;
    logic polling;
    logic pollSecond;
    logic [15:0] pollCnt;
    logic [DATA_W-1:0] prevPoll;
    logic [DATA_W-1:0] readData;
    logic [15:0] timer;
    logic resetN;
    logic start;
    fpcs_cycle_t cyc;
    logic [31:0] rdata;
  } fpcs_host_reg_t;

  fpcs_host_reg_t s;
  fpcs_host_reg_t next_s;
  logic [DATA_W-1:0] bufMem [BUF_MAX];
  logic cycDone;
  logic [DATA_W-1:0] cycRdata;
  fpcs_cycle_t seqCyc;

  // which operations are legal in the current mode
  function automatic logic opLegal(input logic [3:0] op, input logic byp, input logic sec,
                                   input logic acc, input logic [7:0] cnt);
    logic ok;
    ok = 1'b0;
    unique case (op)
      OP_WORD, OP_SEC_ENTER, OP_SEC_EXIT, OP_RESET: ok = !byp;
      OP_BUF_PROG: ok = !byp && (cnt < 8'(BUF_WORDS));
      OP_BYP_ENTER, OP_ACC_ON: ok = !byp && !sec;
      OP_BYP_PROG: ok = byp && !sec;
      OP_BYP_EXIT: ok = byp && !acc;
      OP_ACC_OFF: ok = acc;
      OP_ABORT_RESET, OP_READ, OP_HW_RESET: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic fpcs_cycle_t wrCyc(input logic last, input logic [ADDR_W-1:0] a,
                                        input logic [DATA_W-1:0] d);
    return '{last: last, wr: 1'b1, addr: a, data: d};
  endfunction

  // bus cycle for a given step of an operation
  function automatic fpcs_cycle_t stepCyc(input logic [3:0] op, input logic [4:0] step,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [DATA_W-1:0] d,
                                          input logic [7:0] cnt,
                                          input logic [DATA_W-1:0] bufWord);
    fpcs_cycle_t c;
    logic [4:0] dataEnd;
    c = wrCyc(1'b1, a, d);
    dataEnd = 5'(cnt[3:0]) + 5'h04;
    if (op == OP_READ) begin
      c = '{last: 1'b1, wr: 1'b0, addr: a, data: '0};
    end else if (op == OP_RESET) begin
      c = wrCyc(1'b1, a, RESET_CMD);
    end else if (op == OP_BYP_PROG) begin
      c = (step == 5'h00) ? wrCyc(1'b0, UNLOCK_ADDR1, CMD_BYPASS_PROG)
                          : wrCyc(1'b1, a, d);
    end else if (op == OP_BYP_EXIT) begin
      c = (step == 5'h00) ? wrCyc(1'b0, a, CMD_BYPASS_EXIT1)
                          : wrCyc(1'b1, a, CMD_BYPASS_EXIT2);
    end else if (step == 5'h00) begin
      c = wrCyc(1'b0, UNLOCK_ADDR1, UNLOCK_DATA1);
    end else if (step == 5'h01) begin
      c = wrCyc(1'b0, UNLOCK_ADDR2, UNLOCK_DATA2);
    end else begin
      unique case (op)
        OP_WORD: begin
          c = (step == 5'h02) ? wrCyc(1'b0, UNLOCK_ADDR1, PROG_SETUP)
                              : wrCyc(1'b1, a, d);
        end
        OP_BYP_ENTER: c = wrCyc(1'b1, UNLOCK_ADDR1, CMD_BYPASS_ENTER);
        OP_SEC_ENTER: c = wrCyc(1'b1, UNLOCK_ADDR1, SEC_ENTER);
        OP_SEC_EXIT: begin
          c = (step == 5'h02) ? wrCyc(1'b0, UNLOCK_ADDR1, SEC_EXIT1)
                              : wrCyc(1'b1, a, SEC_EXIT2);
        end
        OP_ABORT_RESET: c = wrCyc(1'b1, UNLOCK_ADDR1, RESET_CMD);
        OP_BUF_PROG: begin
          if (step == 5'h02) begin
            c = wrCyc(1'b0, a, BUF_LOAD);
          end else if (step == 5'h03) begin
            c = wrCyc(1'b0, a, {8'h00, cnt});
          end else if (step <= dataEnd) begin
            // page kept from the start address, index in the low bits
            c = wrCyc(1'b0, {a[ADDR_W-1:4], 4'(step - 5'h04)}, bufWord);
          end else begin
            c = wrCyc(1'b1, a, BUF_CONFIRM);
          end
        end
        default: c = wrCyc(1'b1, a, d);
      endcase
    end
    return c;
  endfunction

  always_comb begin
    seqCyc = stepCyc(s.op, s.step, s.addr, s.data, s.count, bufMem[4'(s.step - 5'h04)]);
  end

  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.rdata = 32'h00000000;

    // register reads, answered one cycle later
    if (regRd) begin
      unique case (regAddr)
        REG_ADDR: next_s.rdata = 32'(s.addr);
        REG_DATA: next_s.rdata = 32'(s.data);
        REG_COUNT: next_s.rdata = 32'(s.count);
        REG_BUFIDX: next_s.rdata = 32'(s.bufIdx);
        REG_STATUS: begin
          next_s.rdata[ST_BUSY] = (s.st != S_IDLE);
          next_s.rdata[ST_BYPASS] = s.bypass;
          next_s.rdata[ST_SECURED] = s.secured;
          next_s.rdata[ST_ACCEL] = s.accHigh;
          next_s.rdata[ST_TIMEOUT] = s.timeoutErr;
          next_s.rdata[ST_ABORT] = s.bufAbort;
          next_s.rdata[ST_REFUSED] = s.refused;
          next_s.rdata[ST_DONE] = s.opDone;
        end
        REG_RDATA: next_s.rdata = 32'(s.readData);
        default: next_s.rdata = 32'h00000000;
      endcase
    end

    // register writes; parameters frozen while an operation runs
    if (regWr && s.st == S_IDLE) begin
      unique case (regAddr)
        REG_ADDR: next_s.addr = regWdata[ADDR_W-1:0];
        REG_DATA: next_s.data = regWdata[DATA_W-1:0];
        REG_COUNT: next_s.count = regWdata[7:0];
        REG_BUFIDX: next_s.bufIdx = regWdata[3:0];
        REG_BUFDATA: next_s.bufIdx = s.bufIdx + 4'h1;
        REG_CTRL: begin
          next_s.timeoutErr = 1'b0;
          next_s.bufAbort = 1'b0;
          next_s.opDone = 1'b0;
          next_s.refused = 1'b0;
          next_s.op = regWdata[3:0];
          next_s.step = 5'h00;
          next_s.polling = 1'b0;
          if (!opLegal(regWdata[3:0], s.bypass, s.secured, s.accHigh, s.count)) begin
            next_s.refused = 1'b1;
          end else if (regWdata[3:0] == OP_HW_RESET) begin
            next_s.resetN = 1'b0;
            next_s.timer = 16'(RST_LOW_CYC - 1);
            next_s.st = S_RST_LOW;
          end else if (regWdata[3:0] == OP_ACC_ON) begin
            next_s.accHigh = 1'b1;
            next_s.bypass = 1'b1;
            next_s.opDone = 1'b1;
          end else if (regWdata[3:0] == OP_ACC_OFF) begin
            next_s.accHigh = 1'b0;
            next_s.bypass = 1'b0;
            next_s.opDone = 1'b1;
          end else begin
            next_s.st = S_ISSUE;
          end
        end
        default: next_s.st = s.st;
      endcase
    end

    unique case (s.st)
      S_IDLE: next_s.st = next_s.st;
      S_ISSUE: begin
        next_s.cyc = seqCyc;
        next_s.start = 1'b1;
        next_s.st = S_WAIT;
      end
      S_WAIT: begin
        if (cycDone && s.polling) begin
          // two reads compared; a steady toggle bit means done
          next_s.prevPoll = cycRdata;
          next_s.pollCnt = s.pollCnt + 16'h0001;
          if (!s.pollSecond) begin
            next_s.pollSecond = 1'b1;
            next_s.start = 1'b1;
          end else if (cycRdata[TOGGLE_STATUS_BIT] == s.prevPoll[TOGGLE_STATUS_BIT]) begin
            next_s.st = S_IDLE;
            next_s.opDone = 1'b1;
            next_s.readData = cycRdata;
          end else if (s.prevPoll[TIMEOUT_ERROR_BIT] && cycRdata[TIMEOUT_ERROR_BIT]) begin
            next_s.timeoutErr = 1'b1;
            next_s.st = S_IDLE;
          end else if (s.op == OP_BUF_PROG && cycRdata[BUFFER_ABORT_BIT]) begin
            next_s.bufAbort = 1'b1;
            next_s.st = S_IDLE;
          end else if (s.pollCnt >= 16'(POLL_LIMIT)) begin
            next_s.timeoutErr = 1'b1;
            next_s.st = S_IDLE;
          end else begin
            next_s.start = 1'b1;
          end
        end else if (cycDone) begin
          if (!s.cyc.last) begin
            next_s.step = s.step + 5'h01;
            next_s.st = S_ISSUE;
          end else if (s.op == OP_WORD || s.op == OP_BYP_PROG || s.op == OP_BUF_PROG) begin
            next_s.polling = 1'b1;
            next_s.pollSecond = 1'b0;
            next_s.pollCnt = 16'h0000;
            next_s.start = 1'b1;
            next_s.cyc.wr = 1'b0;
            next_s.cyc.addr = (s.op == OP_BUF_PROG) ? {s.addr[ADDR_W-1:4], s.count[3:0]}
                                                     : s.addr;
          end else begin
            next_s.st = S_IDLE;
            next_s.opDone = 1'b1;
            unique case (s.op)
              OP_BYP_ENTER: next_s.bypass = 1'b1;
              OP_BYP_EXIT: next_s.bypass = 1'b0;
              OP_SEC_ENTER: next_s.secured = 1'b1;
              OP_SEC_EXIT: next_s.secured = 1'b0;
              OP_READ: next_s.readData = cycRdata;
              default: next_s.bypass = s.bypass;
            endcase
          end
        end
      end
      S_RST_LOW: begin
        if (s.timer == 16'h0000) begin
          next_s.resetN = 1'b1;
          next_s.timer = 16'(RST_RECOVER_CYC - 1);
          next_s.st = S_RST_WAIT;
        end else begin
          next_s.timer = s.timer - 16'h0001;
        end
      end
      S_RST_WAIT: begin
        if (s.timer == 16'h0000) begin
          // device back in read mode; only the pin keeps bypass
          next_s.bypass = s.accHigh;
          next_s.secured = 1'b0;
          next_s.opDone = 1'b1;
          next_s.st = S_IDLE;
        end else begin
          next_s.timer = s.timer - 16'h0001;
        end
      end
      default: next_s.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: S_IDLE, op: 4'h0, step: 5'h00, addr: '0, data: '0, count: 8'h00,
             bufIdx: 4'h0, bypass: 1'b0, secured: 1'b0, accHigh: 1'b0, timeoutErr: 1'b0,
             bufAbort: 1'b0, refused: 1'b0, opDone: 1'b0, polling: 1'b0,
             pollSecond: 1'b0, pollCnt: 16'h0000, prevPoll: '0, readData: '0,
             timer: 16'h0000, resetN: 1'b1, start: 1'b0, cyc: '0, rdata: 32'h00000000};
    end else if (en) begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk) begin
    if (en && regWr && regAddr == REG_BUFDATA && s.st == S_IDLE) begin
      bufMem[s.bufIdx] <= regWdata[DATA_W-1:0];
    end
  end

  fpcs_bus_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .en(en),
    .start(s.start),
    .cyc(s.cyc),
    .done(cycDone),
    .rdata(cycRdata),
    .dqIn(flashDqIn),
    .pins(flashPins)
  );

  assign regRdata = s.rdata;
  assign flashReset_n = s.resetN;
  assign accHighVoltage = s.accHigh;

endmodule
`default_nettype wire

// >>> sim/fpcs_host_assertions.sv
// pin timing checks of the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fpcs_host_assertions import fpcs_pkg::*; (
  // watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire fpcs_pins_t flashPins,
  input wire logic flashReset_n
);
  fpcs_pins_t p;
  assign p = flashPins;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_ADDR_SETUP: assert property ($fell(p.we_n) |-> !p.ce_n && $stable(p.addr))
    else $error("address moved at strobe");
  AST_DATA_HOLD: assert property ($rose(p.we_n) |-> !p.ce_n && !p.dqOe_n && $stable(p.dq))
    else $error("data not held");
  AST_WE_WIDTH: assert property ($fell(p.we_n) |-> !p.we_n [*4])
    else $error("strobe too short");
  AST_WE_GAP: assert property ($rose(p.we_n) |-> p.we_n [*3])
    else $error("strobe gap too short");
  AST_NO_FIGHT: assert property (!p.oe_n |-> p.dqOe_n && p.we_n)
    else $error("read while driving");
  AST_DRIVE_SEL: assert property (!p.dqOe_n |-> !p.ce_n)
    else $error("driving unselected");
  AST_RST_QUIET: assert property (!flashReset_n |-> p.ce_n && p.we_n)
    else $error("cycle during reset");
  AST_RST_WIDTH: assert property ($fell(flashReset_n) |-> !flashReset_n [*8])
    else $error("reset pulse short");
  cover property ($fell(p.we_n));
  cover property ($fell(p.oe_n));
  cover property ($fell(flashReset_n));
endmodule
bind fpcs_host fpcs_host_assertions fpcs_host_assertions_inst (.clk(clk), .rst_n(rst_n),
  .flashPins(flashPins), .flashReset_n(flashReset_n));
`default_nettype wire

// >>> sim/fpcs_flash_model.sv
// behavioural nor flash answering program sequences
`timescale 1ns/1ps
`default_nettype none
module fpcs_flash_model import fpcs_pkg::*; (
  // flash side
  input wire fpcs_pins_t pins,
  input wire logic reset_n,
  input wire logic accHv,
  output logic [DATA_W-1:0] dqOut
);
  logic [DATA_W-1:0] mem [1024];
  logic [DATA_W-1:0] bq [16];
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] rv;
  logic [ADDR_W-1:0] a;
  logic [9:0] pa;
  logic [9:0] ba;
  logic byp = 0;
  logic sec = 0;
  logic tog = 0;
  int st = 0;
  int bsy = 0;
  int n = 0;
  int k = 0;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  // status while busy, array after
  assign rv = bsy > 0 ? {8'h00, ~mem[pa][7], tog, 6'h00} : mem[pins.addr[9:0]];
  // released bus shows the inverse
  assign dqOut = !pins.oe_n && !pins.ce_n ? rv : ~rv;
  always @(negedge pins.oe_n) if (bsy > 0) begin
    tog = ~tog;
    bsy--;
  end
  always @(accHv) byp = accHv;
  // command table defaults of the host
  always @(posedge pins.we_n or negedge reset_n) begin
    if (!reset_n) begin
      {sec, st, bsy} = 0;
      byp = accHv;
    end else if (!pins.ce_n && bsy == 0) begin
      a = pins.addr;
      d = pins.dq;
      if (byp) begin
        if (st == 5) begin
          mem[a[9:0]] &= d;
          pa = a[9:0];
          {st, bsy} = 3;
        end else if (st == 6 && d == 16'h0000) begin
          {byp, st} = 0;
        end else st = d == 16'h00a0 ? 5 : d == 16'h0090 ? 6 : 0;
      end else if (d == 16'h0088 && st < 7) st = 0;
      else case (st)
        0: st = a == 21'h111 && d == 16'h0011 ? 1 : 0;
        1: st = a == 21'h222 && d == 16'h0022 ? 2 : 0;
        2: begin
          st = d == 16'h0033 ? 3 : d == 16'h0077 ? 4 : d == 16'h0044 ? 7 : 0;
          byp = d == 16'h0020 && !sec;
          sec |= d == 16'h0066;
          ba = a[9:0];
        end
        3: begin
          mem[a[9:0]] &= d;
          pa = a[9:0];
          {st, bsy} = 3;
        end
        4: {sec, st} = 0;
        7: begin
          {n, k} = {d, 32'h0};
          st = d > 15 ? 0 : 8;
        end
        8: begin
          bq[a[3:0]] = d;
          pa = a[9:0];
          k++;
          st = a[9:4] != ba[9:4] ? 0 : k > n ? 9 : 8;
        end
        default: begin
          if (d == 16'h0055 && a[9:0] == ba) begin
            for (int i = 0; i <= n; i++) mem[{ba[9:4], i[3:0]}] &= bq[i];
            bsy = 3;
          end
          st = 0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> sim/fpcs_host_test.sv
// self-checking bench of the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fpcs_host_test import fpcs_pkg::*; ;
  typedef struct {logic [3:0] o; logic [31:0] a; logic [31:0] d; logic [7:0] s;} fpcs_row_t;
  logic clk = 0;
  logic rst_n = 0;
  logic [7:0] regAddr = 0;
  logic [31:0] regWdata = 0;
  logic regWr = 0;
  logic regRd = 0;
  logic en = 1;
  logic [31:0] regRdata;
  logic [31:0] v;
  logic [DATA_W-1:0] flashDqIn;
  fpcs_pins_t flashPins;
  logic flashReset_n;
  logic accHighVoltage;
  int fails = 0;
  int checkCount = 0;
  int cyc = 0;
  fpcs_row_t rows [13] = '{'{OP_WORD, 'h100, 'h0f0f, 'h80}, '{OP_SEC_ENTER, 0, 0, 'h84},
    '{OP_BYP_ENTER, 0, 0, 'h44}, '{OP_SEC_EXIT, 0, 0, 'h80}, '{OP_BYP_ENTER, 0, 0, 'h82},
    '{OP_WORD, 'h103, 0, 'h42}, '{OP_BYP_PROG, 'h101, 'h00ff, 'h82},
    '{OP_BYP_EXIT, 0, 0, 'h80}, '{OP_ACC_ON, 0, 0, 'h8a}, '{OP_BYP_PROG, 'h102, 'h1234, 'h8a},
    '{OP_ACC_OFF, 0, 0, 'h80}, '{OP_RESET, 0, 0, 'h80}, '{OP_ABORT_RESET, 0, 0, 'h80}};
  fpcs_host #(.POLL_LIMIT(8)) fpcs_host_inst (.clk(clk), .rst_n(rst_n), .en(en),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .flashDqIn(flashDqIn), .flashPins(flashPins), .flashReset_n(flashReset_n),
    .accHighVoltage(accHighVoltage));
  fpcs_flash_model fpcs_flash_model_inst (.pins(flashPins), .reset_n(flashReset_n),
    .accHv(accHighVoltage), .dqOut(flashDqIn));
  initial forever #5 clk = ~clk;
  task automatic test_done();
    $display("checks %0d errors %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      $display("ERROR %0t timeout", $time);
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checkCount++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic op(input logic [3:0] o, input logic [31:0] a, input logic [31:0] d);
    wr(REG_ADDR, a);
    wr(REG_DATA, d);
    wr(REG_CTRL, {28'h0, o});
    for (int i = 0; i < 600; i++) begin
      rd(REG_STATUS);
      if (v[ST_DONE] === 1'b1 || v[ST_REFUSED] === 1'b1) break;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      op(rows[i].o, rows[i].a, rows[i].d);
      chk(v[7:0], rows[i].s);
    end
    chk(fpcs_flash_model_inst.mem['h100], 'h0f0f);
    chk(fpcs_flash_model_inst.mem['h102], 'h1234);
    op(OP_WORD, 'h100, 'hf0ff);
    op(OP_READ, 'h100, 0);
    rd(REG_RDATA);
    chk(v, 'h000f);
    wr(REG_COUNT, 'h10);
    op(OP_BUF_PROG, 'h200, 0);
    chk(v[7:0], 'h40);
    wr(REG_COUNT, 2);
    wr(REG_BUFIDX, 0);
    for (int i = 1; i < 4; i++) wr(REG_BUFDATA, 'h1111 * i);
    op(OP_BUF_PROG, 'h200, 0);
    chk(fpcs_flash_model_inst.mem['h202], 'h3333);
    chk(fpcs_flash_model_inst.mem['h200], 'h1111);
    op(OP_BYP_EXIT, 0, 0);
    chk(v[7:0], 'h40);
    op(OP_HW_RESET, 0, 0);
    chk(v[7:0], 'h80);
    op(OP_ACC_ON, 0, 0);
    chk(accHighVoltage, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk(accHighVoltage, 1'b0);
    rd(REG_STATUS);
    chk(v, 0);
    @(posedge clk);
    en <= 1'b0;
    wr(REG_DATA, 'h5a5a);
    en <= 1'b1;
    rd(REG_DATA);
    chk(v, 0);
    rd(8'hfc);
    chk(v, 0);
    test_done();
  end
endmodule
`default_nettype wire
